// ---- ask_map.svh ----
`ifndef ASK_MAP_SVH
`define ASK_MAP_SVH

// register indices; byte address is four times the index
`define ASK_IDX_TYPE        10'h055
`define ASK_IDX_STYLE       10'h056
`define ASK_IDX_LENGTH      10'h057
`define ASK_IDX_RESID       10'h058
`define ASK_IDX_STATUS      10'h060
`define ASK_DEC_W           12
`define ASK_ADDR_TYPE       {`ASK_IDX_TYPE, 2'b00}
`define ASK_ADDR_STYLE      {`ASK_IDX_STYLE, 2'b00}
`define ASK_ADDR_LENGTH     {`ASK_IDX_LENGTH, 2'b00}
`define ASK_ADDR_RESID      {`ASK_IDX_RESID, 2'b00}
`define ASK_ADDR_STATUS     {`ASK_IDX_STATUS, 2'b00}

// reset values and writable-bit masks
`define ASK_RST_TYPE        8'h11
`define ASK_RST_STYLE       8'h00
`define ASK_RST_LENGTH      8'h08
`define ASK_RST_RESID       8'h00
`define ASK_MASK_STYLE      8'h77
`define ASK_MASK_LENGTH     8'h9F

// field positions
`define ASK_F_TYPE_FALL     7:4
`define ASK_F_TYPE_RISE     3:0
`define ASK_F_STYLE_FALL    6:4
`define ASK_F_STYLE_RISE    2:0
`define ASK_F_LUT_IDX       1:0
`define ASK_F_LEN_X2        7
`define ASK_F_LEN_CNT       4:0
`define ASK_F_ST_AMPL       7:0
`define ASK_F_ST_BUSY       8
`define ASK_F_ST_FALL       9
`define ASK_F_ST_CORR       10
`define ASK_F_HTRANS_ACT    1

// edge type codes
`define ASK_CODE_LIN1       4'h1
`define ASK_CODE_LIN2       4'h2
`define ASK_CODE_LIN3       4'h3
`define ASK_CODE_LUT        4'h4
`define ASK_CODE_LUT_ADPC   4'h5
`define ASK_CODE_LUT_ADP    4'h6

`define ASK_FULL_AMPL       8'hFF
`define ASK_VNOM_DEF        8'h80

`endif

// ---- ask_pkg.sv ----
`default_nettype none
package ask_pkg;
    typedef enum logic [1:0] {ASK_IDLE, ASK_RAMP, ASK_CORR} ask_state_e;
    typedef logic [7:0] ask_level_t;
    typedef logic [3:0] ask_code_t;
endpackage
`default_nettype wire

// ---- ask_edge_engine.sv ----
`timescale 1ns/100ps
`default_nettype none

module ask_edge_engine #(
    parameter int CW = 5
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          carrier_tick,
    input  wire logic          start,
    input  wire logic [CW-1:0] count,
    input  wire logic          stretch,
    input  wire logic          extra,
    output logic      [CW-1:0] step_idx,
    output logic               in_corr,
    output logic               busy
);

    ask_pkg::ask_state_e state_q;
    ask_pkg::ask_state_e state_d;
    logic [CW-1:0]       idx_q;
    logic [CW-1:0]       idx_d;
    logic [CW-1:0]       count_q;
    logic                stretch_q;
    logic                extra_q;
    logic                hold_q;
    logic                hold_d;
    logic                hold_done;
    logic                last;

    // a state ends on its first tick, or on its second when stretched
    assign hold_done = carrier_tick && (hold_q == stretch_q); // see [R10] see [R11]
    assign last      = (idx_q == count_q); // see [R12]

    always_comb
    begin
        state_d = state_q;
        idx_d   = idx_q;
        hold_d  = carrier_tick ? ~hold_q : hold_q;
        if (start)
        begin
            // a new edge restarts from wherever the amplitude stands
            hold_d = 1'b0;
            if (count != '0)
            begin
                state_d = ask_pkg::ASK_RAMP;
                idx_d   = {{(CW-1){1'b0}}, 1'b1};
            end
            else if (extra)
            begin
                state_d = ask_pkg::ASK_CORR;
                idx_d   = '0;
            end
            else
            begin
                state_d = ask_pkg::ASK_IDLE;
                idx_d   = '0;
            end
        end
        else
        begin
            case (state_q)
                ask_pkg::ASK_RAMP:
                begin
                    if (hold_done)
                    begin
                        hold_d = 1'b0;
                        if (!last)
                        begin
                            idx_d = idx_q + {{(CW-1){1'b0}}, 1'b1};
                        end
                        else if (extra_q)
                        begin
                            state_d = ask_pkg::ASK_CORR; // see [R04]
                        end
                        else
                        begin
                            state_d = ask_pkg::ASK_IDLE;
                            idx_d   = '0;
                        end
                    end
                end
                ask_pkg::ASK_CORR:
                begin
                    if (hold_done)
                    begin
                        hold_d  = 1'b0;
                        state_d = ask_pkg::ASK_IDLE;
                        idx_d   = '0;
                    end
                end
                ask_pkg::ASK_IDLE:
                begin
                    hold_d = 1'b0;
                end
                default:
                begin
                    state_d = ask_pkg::ASK_IDLE;
                    idx_d   = '0;
                    hold_d  = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q   <= ask_pkg::ASK_IDLE;
            idx_q     <= '0;
            hold_q    <= 1'b0;
            count_q   <= '0;
            stretch_q <= 1'b0;
            extra_q   <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            idx_q   <= idx_d;
            hold_q  <= hold_d;
            if (start)
            begin
                count_q   <= count;
                stretch_q <= stretch;
                extra_q   <= extra;
            end
        end
    end

    assign step_idx = idx_q;
    assign in_corr  = (state_q == ask_pkg::ASK_CORR);
    assign busy     = (state_q != ask_pkg::ASK_IDLE);

endmodule

`default_nettype wire

// ---- ask_edge_top.sv ----
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ask_map.svh"

// Function
// [R01] The falling edge style comes from bits 7:4 of the edge type register, codes 1 to 3 giving one to three ramps.
// [R02] The rising edge style comes from bits 3:0 of the edge type register with the same code set, independently.
// [R03] Code 4 shapes the edge from a lookup table with no supply adaptation.
// [R04] Code 5 uses a lookup table, adapts to the PA supply and adds a final correction step.
// [R05] Code 6 uses a lookup table and adapts to the PA supply without correction.
// [R06] For firmware shaping on the falling edge, style bits 6:4 are the time constant of that ramp.
// [R07] For table shaping on the falling edge, style bits 6:4 pick table 0 to 3.
// [R08] For firmware shaping on the rising edge, style bits 2:0 are the time constant of that ramp.
// [R09] For table shaping on the rising edge, style bits 2:0 pick table 0 to 3.
// [R10] Length bit 7 clear holds each transition state for one carrier cycle.
// [R11] Length bit 7 set holds each transition state for two carrier cycles.
// [R12] Length bits 4:0 give the number of transition states, shared by both edges.
// [R13] The residual level maps linearly from no carrier at code 0 to full carrier at the top code.
// [R14] Software writes zero to reserved bits and avoids reserved type codes.
module ask_edge_top #(
    parameter int         AW   = 32,
    parameter int         CW   = 5,
    parameter logic [7:0] VNOM = `ASK_VNOM_DEF
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          hsel,
    input  wire logic [AW-1:0] haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic               hresp,
    output logic      [31:0]   hrdata,
    input  wire logic          carrier_tick,
    input  wire logic          mod_req,
    input  wire logic [7:0]    pa_supply_voltage,
    output logic      [7:0]    carrier_amplitude,
    output logic               edge_active,
    output logic               edge_falling
);

    localparam logic [7:0] ASK_K2_T  = 8'h80;
    localparam logic [7:0] ASK_K2_L  = 8'h7F;
    localparam logic [7:0] ASK_K3_A  = 8'h55;
    localparam logic [7:0] ASK_K3_B  = 8'hAA;
    localparam logic [7:0] ASK_K3_L  = 8'h55;
    localparam logic [7:0] ASK_LUT_L = 8'h20;

    // four monotonic shapes: linear, s-curve, fast start, slow start
    localparam logic [7:0] ASK_LUT [0:3][0:8] = '{
        '{8'h00, 8'h20, 8'h40, 8'h60, 8'h80, 8'hA0, 8'hC0, 8'hE0, 8'hFF},
        '{8'h00, 8'h0A, 8'h25, 8'h4F, 8'h80, 8'hB0, 8'hDA, 8'hF5, 8'hFF},
        '{8'h00, 8'h50, 8'h88, 8'hB0, 8'hCE, 8'hE2, 8'hF0, 8'hFA, 8'hFF},
        '{8'h00, 8'h05, 8'h0F, 8'h1D, 8'h31, 8'h4F, 8'h77, 8'hAF, 8'hFF}
    };

    // register select, shared by the write and read decode
    function automatic logic [4:0] ask_sel(input logic [`ASK_DEC_W-1:0] a);
        ask_sel = {a == `ASK_ADDR_STATUS, a == `ASK_ADDR_RESID, a == `ASK_ADDR_LENGTH,
                   a == `ASK_ADDR_STYLE, a == `ASK_ADDR_TYPE};
    endfunction

    // position of state k in an n-state edge, 0..255
    function automatic logic [7:0] ask_frac(input logic [CW-1:0] k, input logic [CW-1:0] n);
        logic [12:0] p;
        logic [12:0] q;
        p = 13'(k) * 13'h00FF;
        q = (n == '0) ? 13'h00FF : p / 13'(n);
        ask_frac = q[7:0];
    endfunction

    // straight line from (t0,y0) over len positions to y1, y1 not below y0
    function automatic logic [7:0] ask_seg(input logic [7:0] t, input logic [7:0] t0, input logic [7:0] len,
                                           input logic [7:0] y0, input logic [7:0] y1);
        logic [15:0] d;
        logic [15:0] r;
        d = ({8'h00, t} - {8'h00, t0}) * ({8'h00, y1} - {8'h00, y0});
        r = {8'h00, y0} + d / {8'h00, len};
        ask_seg = r[7:0];
    endfunction

    // piecewise linear ramps; the time constant moves the knees
    function automatic logic [7:0] ask_fw_shape(input logic [3:0] code, input logic [2:0] tc, input logic [7:0] t);
        logic [7:0] k2;
        logic [7:0] k3a;
        logic [7:0] k3b;
        k2  = {tc, 5'h10};
        k3a = {1'b0, tc, 4'h8};
        k3b = 8'h88 + {1'b0, tc, 4'h0};
        case (code)
            `ASK_CODE_LIN2:
            begin
                ask_fw_shape = (t < ASK_K2_T) ? ask_seg(t, 8'h00, ASK_K2_T, 8'h00, k2)
                                              : ask_seg(t, ASK_K2_T, ASK_K2_L, k2, 8'hFF);
            end
            `ASK_CODE_LIN3:
            begin
                if (t < ASK_K3_A)
                begin
                    ask_fw_shape = ask_seg(t, 8'h00, ASK_K3_L, 8'h00, k3a);
                end
                else if (t < ASK_K3_B)
                begin
                    ask_fw_shape = ask_seg(t, ASK_K3_A, ASK_K3_L, k3a, k3b);
                end
                else
                begin
                    ask_fw_shape = ask_seg(t, ASK_K3_B, ASK_K3_L, k3b, 8'hFF);
                end
            end
            default:
            begin
                ask_fw_shape = t;
            end
        endcase
    endfunction

    // interpolate between the nine points of the chosen table
    function automatic logic [7:0] ask_lut_shape(input logic [1:0] sel, input logic [7:0] t);
        logic [3:0] i;
        logic [3:0] j;
        i = {1'b0, t[7:5]};
        j = i + 4'h1;
        ask_lut_shape = (t == 8'hFF) ? 8'hFF
                                     : ask_seg(t, {t[7:5], 5'h00}, ASK_LUT_L, ASK_LUT[sel][i], ASK_LUT[sel][j]);
    endfunction

    // amplitude between s and e at fraction f of 255
    function automatic logic [7:0] ask_mix(input logic [7:0] s, input logic [7:0] e, input logic [7:0] f);
        logic [15:0] d;
        logic [15:0] r;
        if (e >= s)
        begin
            d = ({8'h00, e} - {8'h00, s}) * {8'h00, f};
            r = {8'h00, s} + d / 16'h00FF;
        end
        else
        begin
            d = ({8'h00, s} - {8'h00, e}) * {8'h00, f};
            r = {8'h00, s} - d / 16'h00FF;
        end
        ask_mix = r[7:0];
    endfunction

    // scale by nominal over measured supply so the field strength holds as the supply sags
    function automatic logic [7:0] ask_adapt(input logic [7:0] l, input logic [7:0] v);
        logic [15:0] p;
        logic [15:0] q;
        p = {8'h00, l} * {8'h00, VNOM};
        q = (v == 8'h00) ? 16'hFFFF : p / {8'h00, v};
        ask_adapt = (q > 16'h00FF) ? 8'hFF : q[7:0];
    endfunction

    // register file and bus
    logic [7:0]             type_q;
    logic [7:0]             style_q;
    logic [7:0]             length_q;
    logic [7:0]             resid_q;
    logic                   wr_q;
    logic                   rd_q;
    logic [`ASK_DEC_W-1:0]  addr_q;
    logic                   bus_take;
    logic [4:0]             wsel;
    logic [4:0]             rsel;
    logic [31:0]            status_w;
    logic [31:0]            rdata_w;

    assign bus_take = hsel && htrans[`ASK_F_HTRANS_ACT] && hready;
    assign wsel     = wr_q ? ask_sel(addr_q) : 5'h00;
    assign rsel     = rd_q ? ask_sel(addr_q) : 5'h00;

    // edge engine and shaping state
    logic                   mod_prev_q;
    logic                   falling_q;
    logic [7:0]             start_q;
    logic [7:0]             end_q;
    logic [3:0]             code_q;
    logic [2:0]             tc_q;
    logic [CW-1:0]          cnt_q;
    logic [7:0]             ampl_q;
    logic [7:0]             ampl_d;
    logic                   edge_start;
    logic                   edge_fall;
    ask_pkg::ask_code_t     code_w;
    logic [2:0]             tc_w;
    logic [CW-1:0]          cnt_w;
    logic                   stretch_w;
    logic                   extra_w;
    ask_pkg::ask_level_t    target_w;
    logic                   fw_q;
    logic                   lut_q;
    logic                   adapt_q;
    logic                   adapt_w;
    logic [7:0]             frac_w;
    logic [7:0]             shape_w;
    logic [7:0]             mix_w;
    logic [7:0]             level_w;
    logic [CW-1:0]          step_idx;
    logic                   in_corr;
    logic                   busy;

    assign edge_start = (mod_req != mod_prev_q);
    assign edge_fall  = mod_req;
    assign code_w     = edge_fall ? type_q[`ASK_F_TYPE_FALL] : type_q[`ASK_F_TYPE_RISE]; // see [R01] see [R02]
    assign tc_w       = edge_fall ? style_q[`ASK_F_STYLE_FALL] : style_q[`ASK_F_STYLE_RISE]; // see [R06] see [R08]
    assign cnt_w      = length_q[`ASK_F_LEN_CNT]; // see [R12]
    assign stretch_w  = length_q[`ASK_F_LEN_X2]; // see [R10] see [R11]
    assign extra_w    = (code_w == `ASK_CODE_LUT_ADPC); // see [R04]
    assign adapt_w    = (code_w == `ASK_CODE_LUT_ADPC) || (code_w == `ASK_CODE_LUT_ADP);
    assign target_w   = edge_fall ? resid_q : `ASK_FULL_AMPL; // see [R13]

    assign fw_q    = (code_q >= `ASK_CODE_LIN1) && (code_q <= `ASK_CODE_LIN3);
    assign lut_q   = (code_q >= `ASK_CODE_LUT) && (code_q <= `ASK_CODE_LUT_ADP);
    assign adapt_q = (code_q == `ASK_CODE_LUT_ADPC) || (code_q == `ASK_CODE_LUT_ADP); // see [R04] see [R05]
    assign frac_w  = ask_frac(step_idx, cnt_q);

    // reserved codes fall back to a plain step to the target
    assign shape_w = fw_q  ? ask_fw_shape(code_q, tc_q, frac_w) // see [R01] see [R06] see [R08]
                   : lut_q ? ask_lut_shape(tc_q[`ASK_F_LUT_IDX], frac_w) // see [R03] see [R07] see [R09]
                   : 8'hFF;
    assign mix_w   = ask_mix(start_q, end_q, shape_w);
    assign level_w = in_corr ? end_q // see [R04]
                   : adapt_q ? ask_adapt(mix_w, pa_supply_voltage) // see [R04] see [R05]
                   : mix_w; // see [R03]

    always_comb
    begin
        ampl_d = ampl_q;
        if (edge_start && (cnt_w == '0) && !extra_w)
        begin
            ampl_d = adapt_w ? ask_adapt(target_w, pa_supply_voltage) : target_w;
        end
        else if (busy && !edge_start)
        begin
            ampl_d = level_w;
        end
    end

    ask_edge_engine #(
        .CW           (CW)
    ) u_engine (
        .clk          (clk),
        .rst          (rst),
        .carrier_tick (carrier_tick),
        .start        (edge_start),
        .count        (cnt_w),
        .stretch      (stretch_w),
        .extra        (extra_w),
        .step_idx     (step_idx),
        .in_corr      (in_corr),
        .busy         (busy)
    );

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mod_prev_q <= 1'b0;
            falling_q  <= 1'b0;
            start_q    <= `ASK_FULL_AMPL;
            end_q      <= `ASK_FULL_AMPL;
            code_q     <= `ASK_CODE_LIN1;
            tc_q       <= 3'h0;
            cnt_q      <= '0;
            ampl_q     <= `ASK_FULL_AMPL;
        end
        else
        begin
            mod_prev_q <= mod_req;
            ampl_q     <= ampl_d;
            if (edge_start)
            begin
                // settings are frozen per edge so a write mid-edge cannot tear the ramp
                falling_q <= edge_fall;
                start_q   <= ampl_q;
                end_q     <= target_w;
                code_q    <= code_w;
                tc_q      <= tc_w;
                cnt_q     <= cnt_w;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_q   <= 1'b0;
            rd_q   <= 1'b0;
            addr_q <= '0;
        end
        else
        begin
            wr_q   <= bus_take && hwrite;
            rd_q   <= bus_take && !hwrite;
            addr_q <= bus_take ? haddr[`ASK_DEC_W-1:0] : addr_q;
        end
    end

    // reserved bits are masked off on write and read as zero
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            type_q   <= `ASK_RST_TYPE;
            style_q  <= `ASK_RST_STYLE;
            length_q <= `ASK_RST_LENGTH;
            resid_q  <= `ASK_RST_RESID;
        end
        else
        begin
            type_q   <= wsel[0] ? hwdata[7:0] : type_q;
            style_q  <= wsel[1] ? (hwdata[7:0] & `ASK_MASK_STYLE) : style_q;
            length_q <= wsel[2] ? (hwdata[7:0] & `ASK_MASK_LENGTH) : length_q;
            resid_q  <= wsel[3] ? hwdata[7:0] : resid_q;
        end
    end

    always_comb
    begin
        status_w                  = 32'h0000_0000;
        status_w[`ASK_F_ST_AMPL]  = ampl_q;
        status_w[`ASK_F_ST_BUSY]  = busy;
        status_w[`ASK_F_ST_FALL]  = falling_q;
        status_w[`ASK_F_ST_CORR]  = in_corr;
    end

    // read data is a mux of flops in the data phase, so a write just before is already visible
    assign rdata_w = rsel[0] ? {24'h000000, type_q}
                   : rsel[1] ? {24'h000000, style_q}
                   : rsel[2] ? {24'h000000, length_q}
                   : rsel[3] ? {24'h000000, resid_q}
                   : rsel[4] ? status_w
                   : 32'h0000_0000;

    assign hrdata            = rdata_w;
    assign hreadyout         = 1'b1;
    assign hresp             = 1'b0;
    assign carrier_amplitude = ampl_q;
    assign edge_active       = busy;
    assign edge_falling      = falling_q;

endmodule

`default_nettype wire

// ---- ask_carrier_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module ask_carrier_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic slow,
    output logic      carrier_tick
);
    logic [3:0] div_q;

    // free-running carrier; slow spacing stretches states
    always_ff @(posedge clk)
    begin
        if (rst || div_q == (slow ? 4'h9 : 4'h3))
            div_q <= 4'h0;
        else
            div_q <= div_q + 4'h1;
    end
    assign carrier_tick = !rst && div_q == 4'h0;
endmodule

`default_nettype wire

// ---- ask_edge_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "ask_map.svh"

module ask_edge_checker #(
    parameter int AW = 32
) (
    input wire logic          clk,
    input wire logic          rst,
    input wire logic          hsel,
    input wire logic [AW-1:0] haddr,
    input wire logic [1:0]    htrans,
    input wire logic          hwrite,
    input wire logic [31:0]   hwdata,
    input wire logic          hready,
    input wire logic          hreadyout,
    input wire logic          hresp,
    input wire logic          carrier_tick,
    input wire logic          mod_req,
    input wire logic [7:0]    carrier_amplitude,
    input wire logic          edge_active,
    input wire logic          edge_falling
);
    logic [11:0] a_q;
    logic        w_q, mod_q, x2_q;
    logic [7:0]  typ_q, len_q, res_q, tgt_q, cnt_q;
    logic [4:0]  n_q;
    logic [3:0]  c_q;
    wire  [3:0]  code = mod_req ? typ_q[7:4] : typ_q[3:0];

    // shadow settings; each edge is judged on what it latched
    always_ff @(posedge clk)
    begin
        w_q <= !rst && hsel && htrans[1] && hready && hwrite;
        a_q <= haddr[11:0];
        mod_q <= rst ? 1'b0 : mod_req;
    end
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            typ_q <= `ASK_RST_TYPE;
            len_q <= `ASK_RST_LENGTH;
            res_q <= `ASK_RST_RESID;
        end
        else if (w_q && a_q == `ASK_ADDR_TYPE)
            typ_q <= hwdata[7:0];
        else if (w_q && a_q == `ASK_ADDR_LENGTH)
            len_q <= hwdata[7:0] & `ASK_MASK_LENGTH;
        else if (w_q && a_q == `ASK_ADDR_RESID)
            res_q <= hwdata[7:0];
    end
    always_ff @(posedge clk)
    begin
        if (mod_req != mod_q)
        begin
            n_q <= len_q[4:0];
            x2_q <= len_q[7];
            c_q <= code;
            tgt_q <= mod_req ? res_q : 8'hFF;
            cnt_q <= 8'h00;
        end
        else if (carrier_tick && edge_active)
            cnt_q <= cnt_q + 8'h01;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_start;
        mod_req != mod_q;
    endsequence
    sequence s_done;
        $fell(edge_active);
    endsequence

    property p_dir;
        s_start |=> edge_falling == $past(mod_req);
    endproperty
    a_dir: assert property (p_dir) else $error("edge direction wrong");
    property p_busy;
        s_start ##0 (len_q[4:0] != 5'h0 || code == 4'h5) |=> edge_active;
    endproperty
    a_busy: assert property (p_busy) else $error("edge did not start");
    property p_zero;
        s_start ##0 (len_q[4:0] == 5'h0 && code != 4'h5) |=> !edge_active ##[0:1] carrier_amplitude == tgt_q;
    endproperty
    a_zero: assert property (p_zero) else $error("empty edge not a jump");
    property p_len1;
        s_done ##0 (!x2_q && c_q != 4'h5) |-> cnt_q == {3'h0, n_q};
    endproperty
    a_len1: assert property (p_len1) else $error("single state length wrong");
    property p_len2;
        s_done ##0 (x2_q && c_q != 4'h5) |-> cnt_q == {2'h0, n_q, 1'b0};
    endproperty
    a_len2: assert property (p_len2) else $error("stretched state length wrong");
    property p_corr;
        s_done ##0 c_q == 4'h5 |-> cnt_q == (({3'h0, n_q} + 8'h01) << x2_q);
    endproperty
    a_corr: assert property (p_corr) else $error("correction state missing");
    property p_end;
        s_done ##0 (c_q >= 4'h1 && c_q <= 4'h5) |-> carrier_amplitude == tgt_q;
    endproperty
    a_end: assert property (p_end) else $error("edge end level wrong");
    property p_bus;
        hreadyout && !hresp;
    endproperty
    a_bus: assert property (p_bus) else $error("bus wait or error seen");
endmodule

bind ask_edge_top ask_edge_checker #(.AW(AW)) chk_u (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .carrier_tick(carrier_tick), .mod_req(mod_req), .carrier_amplitude(carrier_amplitude),
    .edge_active(edge_active), .edge_falling(edge_falling)
);

`default_nettype wire

// ---- ask_edge_shaping_config_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "ask_map.svh"

module ask_edge_shaping_config_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        mod_req = 1'b0;
    logic        slow = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0]  supply = `ASK_VNOM_DEF;
    logic        carrier_tick, hreadyout, hresp, edge_active, edge_falling, x2;
    logic [31:0] hrdata, rd;
    logic [7:0]  carrier_amplitude, cur, res, v;
    logic [3:0]  fc, rc;
    logic [4:0]  n;
    logic [11:0] ra [5] = '{`ASK_ADDR_TYPE, `ASK_ADDR_STYLE, `ASK_ADDR_LENGTH, `ASK_ADDR_RESID, 12'h150};
    logic [7:0]  rv [5] = '{`ASK_RST_TYPE, `ASK_RST_STYLE, `ASK_RST_LENGTH, `ASK_RST_RESID, 8'h00};
    logic [7:0]  rm [5] = '{8'hFF, `ASK_MASK_STYLE, `ASK_MASK_LENGTH, 8'hFF, 8'h00};
    int          err_total = 0;
    int          n_tests = 0;

    ask_edge_top dut_u (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .carrier_tick(carrier_tick), .mod_req(mod_req), .pa_supply_voltage(supply),
        .carrier_amplitude(carrier_amplitude), .edge_active(edge_active), .edge_falling(edge_falling)
    );
    ask_carrier_model car_u (.clk(clk), .rst(rst), .slow(slow), .carrier_tick(carrier_tick));

    initial
    begin
        forever #25 clk = ~clk;
    end

    task automatic end_sim;
        if (err_total == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hwait;
        for (int i = 0; i < 64; i++)
        begin
            @(posedge clk);
            if (hreadyout === 1'b1)
                return;
        end
        err_total++;
        end_sim();
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {20'h0, a};
        hwait();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        hwait();
        rd = hrdata;
    endtask
    // first state level of a linear ramp
    function automatic logic [7:0] lvl1(input logic f, input logic [7:0] s, input logic [7:0] e, input int k);
        int t;
        t = 255 / k;
        return f ? 8'(s - ((s - e) * t) / 255) : 8'(s + ((e - s) * t) / 255);
    endfunction
    task automatic edg(input logic f, input logic [3:0] c);
        int         nt;
        logic [7:0] tgt;
        nt = 0;
        tgt = f ? res : 8'hFF;
        supply <= (c == `ASK_CODE_LUT_ADPC) ? 8'($urandom) : `ASK_VNOM_DEF;
        slow <= 1'($urandom);
        mod_req <= f;
        for (int i = 0; i < 4000; i++)
        begin
            @(negedge clk);
            if (i == 1)
                cmp(edge_active, n != 0 || c == `ASK_CODE_LUT_ADPC);
            if (i == 2 && c == `ASK_CODE_LIN1 && n != 0)
                cmp(carrier_amplitude, lvl1(f, cur, tgt, n));
            if (carrier_tick === 1'b1 && edge_active === 1'b1)
                nt++;
            if (i > 1 && edge_active !== 1'b1)
                break;
        end
        if (edge_active !== 1'b0)
        begin
            err_total++;
            end_sim();
        end
        cmp(nt, (n + (c == `ASK_CODE_LUT_ADPC)) * (x2 + 1));
        cmp(carrier_amplitude, tgt);
        cmp(edge_falling, f);
        cur = tgt;
        @(posedge clk);
        bus(0, `ASK_ADDR_STATUS, 0);
        cmp(rd, {22'h0, f, 1'b0, tgt});
    endtask

    initial
    begin
        void'($urandom(67027));
        cur = 8'hFF;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // upper bits set: must read as zero
        for (int i = 0; i < 5; i++)
        begin
            v = 8'($urandom);
            bus(0, ra[i], 0);
            cmp(rd, rv[i]);
            bus(1, ra[i], {24'hFFFFFF, v});
            bus(0, ra[i], 0);
            cmp(rd, v & rm[i]);
        end
        for (int k = 0; k < 24; k++)
        begin
            fc = 4'(k % 6 + 1);
            rc = 4'((k + 3) % 6 + 1);
            n = (k == 0) ? 5'h00 : (k == 1) ? 5'h1F : 5'($urandom_range(8, 1));
            x2 = (k == 1) || 1'($urandom);
            res = 8'($urandom);
            bus(1, `ASK_ADDR_TYPE, {fc, rc});
            bus(1, `ASK_ADDR_STYLE, $urandom & 32'h77);
            bus(1, `ASK_ADDR_LENGTH, {x2, 2'b00, n});
            bus(1, `ASK_ADDR_RESID, res);
            edg(1'b1, fc);
            edg(1'b0, rc);
        end
        end_sim();
    end
endmodule

`default_nettype wire
